// File: chg_defines.svh
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH
`define CHG_SLAVE_ADDR 7'h6B
`define CHG_FIRST_SET_REG 8'h00
`define CHG_LAST_SET_REG 8'h08
`define CHG_FAULT_REG 8'h09
`define CHG_SET_RST_VAL 8'h00
`define CHG_BOOST_FAULT_BIT 6
`define CHG_BAT_FAULT_BIT 5
`define CHG_THERM_LSB 0
`define CHG_THERM_MSB 2
`define CHG_MCLK_HZ 25000000
`define CHG_INT_PULSE_US 256
`define CHG_INT_CYCLES ((`CHG_INT_PULSE_US * (`CHG_MCLK_HZ / 1000000)))
`define CHG_INT_CNT_W 13
`endif

// File: chg_pkg.sv
package chg_pkg;
  typedef enum logic [2:0] {
    CHG_IDLE = 3'h0,
    CHG_ADDR = 3'h1,
    CHG_ACK = 3'h3,
    CHG_RX = 3'h2,
    CHG_TX = 3'h6,
    CHG_TXACK = 3'h7,
    CHG_NACK = 3'h5
  } chg_state_t;
  typedef struct packed {
    logic boost_ovp;
    logic bat_ovp;
    logic sys_ovp;
    logic sys_ocp;
    logic bat_short;
    logic supply_insert;
    logic [2:0] therm;
  } chg_prot_t;
  typedef struct packed {
    logic stop_switch;
    logic exit_boost;
    logic charge_off;
    logic low_current;
    logic path_switch_on;
  } chg_ctl_t;
endpackage : chg_pkg

// File: chg_sync.sv
`timescale 1ns/100ps
`default_nettype none
module chg_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic s1_q;
  // idle-high bus: reset to one so no false start appears
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      q <= 1'b1;
    end else begin
      s1_q <= d;
      q <= s1_q;
    end
  end
endmodule : chg_sync
`default_nettype wire

// File: chg_int_pulse.sv
`timescale 1ns/100ps
`default_nettype none
`include "chg_defines.svh"
module chg_int_pulse (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic trig,
  output logic int_n
);
  logic [`CHG_INT_CNT_W-1:0] cnt_q;
  // a trigger during a pulse restarts it rather than being dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      int_n <= 1'b1;
    end else if (trig) begin
      cnt_q <= `CHG_INT_CNT_W'(`CHG_INT_CYCLES - 1);
      int_n <= 1'b0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      int_n <= 1'b1;
    end
  end
endmodule : chg_int_pulse
`default_nettype wire

// File: chg_i2c_slave.sv
`timescale 1ns/100ps
`default_nettype none
`include "chg_defines.svh"
// Summary of operation
// - answer only address 6BH, never master
// - supports 100k and 400k bus rates
// - open-drain lines, pull low or release
// - sda changes only while scl low
// - busy from start until stop
// - eight bits per byte, msb first
// - ack follows each byte, master clocks
// - sender releases sda, receiver pulls low
// - slave may stretch scl between bytes
// - first byte: address plus direction bit
// - undefined register address gets nack, idle
// - sequential access over setting registers 0-8
// - fault latch held until read, then clears
// - fault register excluded from sequential access
// - boost input overvoltage: stop, exit, flag, interrupt
// - battery overvoltage: disable charge, flag, interrupt
// - system rail overvoltage stops converter
// - battery short: low safety charge current
// - overcurrent latches path switch off
// - interrupt events give fixed low pulse
// - no new fault interrupt until read
module chg_i2c_slave (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire chg_pkg::chg_prot_t prot_i,
  input wire logic stretch_req,
  output chg_pkg::chg_ctl_t ctl_o,
  output logic [71:0] settings_o,
  output logic bus_busy,
  output logic int_n
);
  logic scl_s, sda_s, scl_p_q, sda_p_q;
  chg_pkg::chg_prot_t prot_s;
  chg_pkg::chg_state_t state_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] ptr_q;
  logic ptr_set_q;
  logic rw_q;
  // set once the pointer has moved or a byte has gone to the fault register inside a transfer; keeps the fault latch single-access
  logic moved_q;
  logic [7:0] regs_q [0:8];
  logic [7:0] fault_q;
  logic fault_pend_q;
  logic int_trig;
  logic [6:0] fault_ev;
  logic path_off_q, supply_p_q;
  logic fault_rd;
  logic [7:0] tx_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // bus and protection pins are asynchronous and pass two flops first; stretch_req is used as it comes
  chg_sync u_scl (.mclk(mclk), .rst_n(rst_n), .d(scl_i), .q(scl_s));
  chg_sync u_sda (.mclk(mclk), .rst_n(rst_n), .d(sda_i), .q(sda_s));
  for (genvar g = 0; g < 9; g++) begin : g_prot
    chg_sync u_p (.mclk(mclk), .rst_n(rst_n), .d(~prot_i[g]), .q(prot_s[g]));
  end
  // prot_s holds inverted levels because the synchroniser resets high

  function automatic logic in_settings(input logic [7:0] a);
    in_settings = (a <= `CHG_LAST_SET_REG);
  endfunction : in_settings

  function automatic logic defined_reg(input logic [7:0] a);
    defined_reg = in_settings(a) || (a == `CHG_FAULT_REG);
  endfunction : defined_reg

  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_busy <= 1'b0;
    end else if (start_c) begin
      bus_busy <= 1'b1;
    end else if (stop_c) begin
      bus_busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // byte engine
  assign tx_byte = (ptr_q == `CHG_FAULT_REG && !moved_q) ? fault_q :
                   (in_settings(ptr_q) ? regs_q[ptr_q[3:0]] : 8'h00);
  wire [7:0] rx_byte = {sh_q[6:0], sda_s};
  assign fault_rd = (state_q == chg_pkg::CHG_TXACK) && scl_rise && rw_q
                    && (ptr_q == `CHG_FAULT_REG) && !moved_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= chg_pkg::CHG_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ptr_q <= 8'h00;
      ptr_set_q <= 1'b0;
      rw_q <= 1'b0;
      moved_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      state_q <= chg_pkg::CHG_ADDR;
      bit_q <= 4'h0;
      moved_q <= 1'b0;
      sda_oe <= 1'b0;
      ptr_set_q <= 1'b0;
    end else if (stop_c) begin
      state_q <= chg_pkg::CHG_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_q)
        chg_pkg::CHG_ADDR, chg_pkg::CHG_RX: begin
          if (scl_rise) begin
            sh_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (state_q == chg_pkg::CHG_ADDR) begin
              if (sh_q[7:1] == `CHG_SLAVE_ADDR) begin
                rw_q <= sh_q[0];
                sda_oe <= 1'b1;
                state_q <= chg_pkg::CHG_ACK;
              end else begin
                state_q <= chg_pkg::CHG_IDLE;
              end
            end else if (!ptr_set_q) begin
              if (defined_reg(sh_q)) begin
                ptr_q <= sh_q;
                ptr_set_q <= 1'b1;
                sda_oe <= 1'b1;
                state_q <= chg_pkg::CHG_ACK;
              end else begin
                state_q <= chg_pkg::CHG_NACK;
              end
            end else if (in_settings(ptr_q)) begin
              sda_oe <= 1'b1;
              ptr_q <= ptr_q + 8'h01;
              moved_q <= 1'b1;
              state_q <= chg_pkg::CHG_ACK;
            end else if (ptr_q == `CHG_FAULT_REG && !moved_q) begin
              sda_oe <= 1'b1;
              moved_q <= 1'b1;
              state_q <= chg_pkg::CHG_ACK;
            end else begin
              state_q <= chg_pkg::CHG_NACK;
            end
          end
        end
        chg_pkg::CHG_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              sda_oe <= ~tx_byte[7];
              sh_q <= {tx_byte[6:0], 1'b0};
              bit_q <= 4'h1;
              state_q <= chg_pkg::CHG_TX;
            end else begin
              sda_oe <= 1'b0;
              state_q <= chg_pkg::CHG_RX;
              if (ptr_set_q && bit_q == 4'h0 && ptr_q != `CHG_FAULT_REG
                  && state_q == chg_pkg::CHG_ACK) begin
                bit_q <= 4'h0;
              end
            end
          end
        end
        chg_pkg::CHG_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oe <= 1'b0;
              state_q <= chg_pkg::CHG_TXACK;
            end else begin
              sda_oe <= ~sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        chg_pkg::CHG_TXACK: begin
          if (scl_rise) begin
            if (sda_s || ptr_q == `CHG_FAULT_REG) begin
              state_q <= chg_pkg::CHG_NACK;
            end else begin
              ptr_q <= ptr_q + 8'h01;
              moved_q <= 1'b1;
              state_q <= chg_pkg::CHG_ACK;
            end
            bit_q <= 4'h0;
          end
        end
        chg_pkg::CHG_NACK: begin
          sda_oe <= 1'b0;
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // stretching only ever holds scl low between bytes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scl_o <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      scl_oe <= stretch_req && ~scl_s && (state_q == chg_pkg::CHG_ACK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // setting registers, written one byte per data phase
  wire wr_data = (state_q == chg_pkg::CHG_RX) && ptr_set_q && scl_fall
                 && (bit_q == 4'h8) && in_settings(ptr_q) && !start_c && !stop_c;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 9; i++) begin
        regs_q[i] <= `CHG_SET_RST_VAL;
      end
    end else if (wr_data) begin
      regs_q[ptr_q[3:0]] <= sh_q;
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < 9; i++) begin
      settings_o[i*8 +: 8] <= regs_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protection and fault latch
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      supply_p_q <= 1'b0;
      path_off_q <= 1'b0;
    end else begin
      supply_p_q <= ~prot_s.supply_insert;
      if (~prot_s.supply_insert && !supply_p_q) begin
        path_off_q <= 1'b0;
      end else if (~prot_s.sys_ocp) begin
        path_off_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl_o <= '0;
    end else begin
      ctl_o.stop_switch <= ~prot_s.sys_ovp | ~prot_s.boost_ovp;
      ctl_o.exit_boost <= ~prot_s.boost_ovp;
      ctl_o.charge_off <= ~prot_s.bat_ovp;
      ctl_o.low_current <= ~prot_s.bat_short;
      ctl_o.path_switch_on <= ~path_off_q;
    end
  end

  assign fault_ev = {~prot_s.boost_ovp, ~prot_s.bat_ovp, 5'h00};
  wire new_fault = |(fault_ev & ~fault_q[6:0]);
  wire [2:0] therm_now = ~prot_s.therm;

  // a fault arriving with the read wins over the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fault_q <= 8'h00;
      fault_pend_q <= 1'b0;
    end else begin
      fault_q[`CHG_THERM_MSB:`CHG_THERM_LSB] <= therm_now;
      if (fault_rd) begin
        fault_q[`CHG_BOOST_FAULT_BIT] <= fault_ev[6];
        fault_q[`CHG_BAT_FAULT_BIT] <= fault_ev[5];
        fault_pend_q <= |fault_ev[6:5];
      end else begin
        fault_q[`CHG_BOOST_FAULT_BIT] <= fault_q[6] | fault_ev[6];
        fault_q[`CHG_BAT_FAULT_BIT] <= fault_q[5] | fault_ev[5];
        if (new_fault) begin
          fault_pend_q <= 1'b1;
        end
      end
    end
  end

  logic [2:0] therm_p_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      therm_p_q <= 3'h0;
    end else begin
      therm_p_q <= therm_now;
    end
  end

  // latched faults interrupt only while nothing is pending; thermistor always
  assign int_trig = (new_fault && !fault_pend_q) || (therm_now != therm_p_q);

  chg_int_pulse u_int (.mclk(mclk), .rst_n(rst_n), .trig(int_trig), .int_n(int_n));
endmodule : chg_i2c_slave
`default_nettype wire

// File: chg_i2c_slave_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module chg_i2c_slave_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire chg_pkg::chg_prot_t prot_i,
  input wire logic stretch_req,
  input wire chg_pkg::chg_ctl_t ctl_o,
  input wire logic [71:0] settings_o,
  input wire logic bus_busy,
  input wire logic int_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  pull_only_a: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  sda_hold_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda moved with scl high");
  busy_set_a: assert property (scl_i && $fell(sda_i) |-> ##[1:6] bus_busy)
    else $error("busy not set");
  busy_clr_a: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !bus_busy)
    else $error("busy not cleared");
  idle_quiet_a: assert property (!bus_busy |-> !sda_oe && !scl_oe)
    else $error("drive on free bus");
  stretch_low_a: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("stretch with scl high");
  int_pulse_a: assert property ($fell(int_n) |=> !int_n [*8])
    else $error("short interrupt");
  boost_stop_a: assert property (prot_i.boost_ovp |-> ##[1:5] ctl_o.exit_boost)
    else $error("boost kept");
  bat_off_a: assert property (prot_i.bat_ovp |-> ##[1:5] ctl_o.charge_off)
    else $error("charge kept");
  path_off_a: assert property (prot_i.sys_ocp |-> ##[1:5] !ctl_o.path_switch_on)
    else $error("path kept on");
  cover property ($fell(int_n));
  cover property ($rose(scl_oe));
  cover property ($rose(sda_oe));
endmodule : chg_i2c_slave_asserts
bind chg_i2c_slave chg_i2c_slave_asserts u_chg_i2c_slave_asserts (.mclk(mclk), .rst_n(rst_n),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .prot_i(prot_i), .stretch_req(stretch_req), .ctl_o(ctl_o),
  .settings_o(settings_o), .bus_busy(bus_busy), .int_n(int_n));
`default_nettype wire

// File: chg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module chg_host_model (
  input wire logic mclk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic hung
);
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    hung = 1'b0;
  end
  // data moves mid low phase, never beside the scl edge
  task half(input logic s);
    int n;
    n = 0;
    repeat (2) @(posedge mclk);
    sda_pull <= s;
    repeat (3) @(posedge mclk);
    scl_pull <= 1'b0;
    @(posedge mclk);
    while (!scl && n < 20000) begin
      n++;
      @(posedge mclk);
    end
    if (!scl) hung <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : half
  task start;
    half(1'b0);
    sda_pull <= 1'b1;
    repeat (2) @(posedge mclk);
    scl_pull <= 1'b1;
  endtask : start
  task stop;
    half(1'b1);
    sda_pull <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask : stop
  task bitx(input logic b, output logic r);
    half(!b);
    r = sda;
    scl_pull <= 1'b1;
  endtask : bitx
  task byte_x(input logic [7:0] d, input logic ai, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(ai, ak);
  endtask : byte_x
endmodule : chg_host_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk, rst_n, scl, sda, stretch_req, scl_pull, sda_pull, hung, a, saw;
  logic scl_o, scl_oe, sda_o, sda_oe, bus_busy, int_n;
  logic [7:0] r;
  logic [7:0] v [0:1];
  logic [71:0] settings_o;
  chg_pkg::chg_prot_t prot_i;
  chg_pkg::chg_ctl_t ctl_o;
  int fail_count, cmp_count;
  assign scl = !((scl_oe && !scl_o) || scl_pull);
  assign sda = !((sda_oe && !sda_o) || sda_pull);
  chg_i2c_slave u_chg_i2c_slave (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .prot_i(prot_i),
    .stretch_req(stretch_req), .ctl_o(ctl_o), .settings_o(settings_o),
    .bus_busy(bus_busy), .int_n(int_n));
  chg_host_model u_chg_host_model (.mclk(mclk), .scl(scl), .sda(sda),
    .scl_pull(scl_pull), .sda_pull(sda_pull), .hung(hung));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (scl_oe === 1'b1) saw <= 1'b1;
    if (hung === 1'b1) begin
      fail_count++;
      print_verdict;
    end
  end
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk
  task chkb(input logic e, input logic g);
    chk({15'h0, e}, {15'h0, g});
  endtask : chkb
  task bbyte(input logic [7:0] d, input logic ai);
    u_chg_host_model.byte_x(d, ai, r, a);
  endtask : bbyte
  task wr(input logic [7:0] rg, input int n, input logic [7:0] d0);
    u_chg_host_model.start;
    bbyte(8'hD6, 1'b1);
    chkb(1'b0, a);
    bbyte(rg, 1'b1);
    chkb(1'b0, a);
    for (int i = 0; i < n; i++) begin
      bbyte(d0 + 8'(i), 1'b1);
      chkb(rg + i > 8, a);
    end
    u_chg_host_model.stop;
  endtask : wr
  task rd(input logic [7:0] rg, input int n);
    u_chg_host_model.start;
    bbyte(8'hD6, 1'b1);
    bbyte(rg, 1'b1);
    u_chg_host_model.start;
    bbyte(8'hD7, 1'b1);
    chkb(1'b0, a);
    for (int i = 0; i < n; i++) begin
      bbyte(8'hFF, i == n - 1);
      v[i] = r;
    end
    u_chg_host_model.stop;
  endtask : rd
  task t_rw;
    wr(8'h00, 3, 8'hA5);
    chk(16'hA6A5, settings_o[15:0]);
    chk(16'h00A7, settings_o[31:16]);
    rd(8'h01, 2);
    chk({v[1], v[0]}, 16'hA7A6);
    wr(8'h08, 2, 8'h3C);
    chk(16'h003C, {8'h00, settings_o[71:64]});
  endtask : t_rw
  task t_refuse;
    u_chg_host_model.start;
    repeat (6) @(posedge mclk);
    chkb(1'b1, bus_busy);
    bbyte(8'hD4, 1'b1);
    chkb(1'b1, a);
    u_chg_host_model.stop;
    repeat (8) @(posedge mclk);
    chkb(1'b0, bus_busy);
    u_chg_host_model.start;
    bbyte(8'hD6, 1'b1);
    bbyte(8'h0A, 1'b1);
    chkb(1'b1, a);
    u_chg_host_model.stop;
  endtask : t_refuse
  task t_stretch;
    stretch_req <= 1'b1;
    fork
      wr(8'h02, 1, 8'h5A);
      begin
        repeat (300) @(posedge mclk);
        stretch_req <= 1'b0;
      end
    join
    chkb(1'b1, saw);
    chk(16'h005A, {8'h00, settings_o[23:16]});
  endtask : t_stretch
  // bounded: a missing pulse gives a zero length
  task int_len(output int n);
    n = 0;
    for (int i = 0; i < 20 && int_n; i++) @(posedge mclk);
    while (!int_n && n < 9000) begin
      n++;
      @(posedge mclk);
    end
  endtask : int_len
  task t_fault;
    int n;
    prot_i.bat_ovp <= 1'b1;
    int_len(n);
    chk(16'h1900, n[15:0]);
    prot_i.bat_ovp <= 1'b0;
    prot_i.boost_ovp <= 1'b1;
    repeat (40) @(posedge mclk);
    chkb(1'b1, int_n);
    prot_i.boost_ovp <= 1'b0;
    rd(8'h09, 1);
    chk(16'h0020, {8'h00, v[0] & 8'h20});
    rd(8'h09, 1);
    chk(16'h0000, {8'h00, v[0]});
    prot_i.boost_ovp <= 1'b1;
    int_len(n);
    chk(16'h1900, n[15:0]);
    prot_i <= 9'h061;
    repeat (10) @(posedge mclk);
    chkb(1'b0, ctl_o.path_switch_on);
    rd(8'h09, 1);
    chk(16'h0041, {8'h00, v[0] & 8'h47});
    prot_i <= 9'h008;
    repeat (10) @(posedge mclk);
    chkb(1'b1, ctl_o.path_switch_on);
  endtask : t_fault
  initial begin
    rst_n = 1'b0;
    stretch_req = 1'b0;
    prot_i = '0;
    saw = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_rw;
    t_refuse;
    t_stretch;
    t_fault;
    print_verdict;
  end
endmodule : tb_top
`default_nettype wire
